// *** pkg/scm_pkg.sv ***
// Constants shared by the switching clock manager design files
package scm_pkg;

    // ------------------------------------------------------------
    // Clock
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam int CTRL_FREQ_LSB = 0;
    localparam int CTRL_SPREAD_EN_BIT = 4;
    localparam int CTRL_RATE_BIT = 5;
    localparam int CTRL_MODE_LSB = 6;
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_EXT_BIT = 1;
    localparam int STAT_PIN_BIT = 2;
    localparam int STAT_PFM_BIT = 3;
    localparam logic RATE_SEL_RESET = 1'b0;

    // ------------------------------------------------------------
    // Oscillator codes and modes
    // ------------------------------------------------------------
    localparam logic [3:0] FREQ_HI_MAX = 4'h4;
    localparam logic [3:0] FREQ_LO_MIN = 4'h9;
    localparam logic [3:0] FREQ_LO_MAX = 4'hC;
    localparam logic [3:0] FREQ_RESET = 4'h0;
    localparam logic [1:0] MODE_PFM = 2'h0;
    localparam logic [1:0] GP2_CLOCK_EXPORT = 2'h2;

    // ------------------------------------------------------------
    // Divider ratios
    // ------------------------------------------------------------
    localparam int DIV_W = 7;
    localparam logic [6:0] FAST_DIV_A = 7'h08;
    localparam logic [6:0] FAST_DIV_B = 7'h09;
    localparam logic [6:0] SLOW_DIV_A = 7'h30;
    localparam logic [6:0] SLOW_DIV_B = 7'h40;

    // ------------------------------------------------------------
    // Spreading
    // ------------------------------------------------------------
    localparam int unsigned SPREAD_RANGE_PCT = 5;
    localparam int unsigned SPREAD_SLOW_HZ = 23_500;
    localparam int unsigned SPREAD_FAST_HZ = 94_000;
    localparam logic [4:0] SPREAD_STEPS = 5'h10;
    localparam logic [5:0] SPREAD_SLOW_CYC =
        6'(CLK_HZ / (SPREAD_SLOW_HZ * 2 * int'(SPREAD_STEPS)));
    localparam logic [5:0] SPREAD_FAST_CYC =
        6'(CLK_HZ / (SPREAD_FAST_HZ * 2 * int'(SPREAD_STEPS)));

    // ------------------------------------------------------------
    // Sync frequency watchdog
    // ------------------------------------------------------------
    localparam int unsigned SYNC_A_MIN_KHZ = 2000;
    localparam int unsigned SYNC_A_MAX_KHZ = 3000;
    localparam int unsigned SYNC_B_MIN_KHZ = 333;
    localparam int unsigned SYNC_B_MAX_KHZ = 500;
    localparam logic [7:0] SYNC_A_PER_MIN = 8'(CLK_KHZ / SYNC_A_MAX_KHZ);
    localparam logic [7:0] SYNC_A_PER_MAX = 8'((CLK_KHZ + SYNC_A_MIN_KHZ - 1) / SYNC_A_MIN_KHZ);
    localparam logic [7:0] SYNC_B_PER_MIN = 8'(CLK_KHZ / SYNC_B_MAX_KHZ);
    localparam logic [7:0] SYNC_B_PER_MAX = 8'((CLK_KHZ + SYNC_B_MIN_KHZ - 1) / SYNC_B_MIN_KHZ);
    localparam logic [7:0] SYNC_PER_SAT = 8'hFF;
    localparam logic [1:0] SYNC_GOOD_PERIODS = 2'h3;

endpackage : scm_pkg

// *** core/scm_divider.sv ***
// Restartable divider giving one-cycle pulses at a selectable ratio
`timescale 1ns/1ps
module scm_divider #(
    parameter int W = 7
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic restart_in,
    input wire logic [W-1:0] ratio_in,
    output logic pulse_out
);
    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    logic pulse_q;
    logic pulse_d;

    always_comb begin
        count_d = W'(count_q + 1'b1);
        pulse_d = 1'b0;
        if (count_q >= W'(ratio_in - 1'b1)) begin
            count_d = '0;
            pulse_d = 1'b1;
        end else if (restart_in) begin
            // Late edge fires now, early edge delays: starved if edges keep coming before half count, no runt below half
            count_d = '0;
            pulse_d = (count_q >= W'(ratio_in >> 1));
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            count_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            count_q <= count_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse_out = pulse_q;
endmodule : scm_divider

// *** core/scm_clock_manager.sv ***
// Switching clock manager: oscillator control, dividers, sync watchdog, APB registers
`timescale 1ns/1ps
//
// Contract
// - Oscillator code 0-4 gives 20-24 MHz, 9-12 gives 16-19 MHz, others unused.
// - Code loads its fused default at reset, or 0 if that default is unused; software may overwrite it later.
// - Spreading runs while spread enable is set; default fused, software writable.
// - Spreading spans 5 percent at about 23.5 kHz or 94 kHz by rate select.
// - Fast switching clock divides the oscillator by 8 or by 9.
// - Slow switching clock divides the oscillator by 48 or by 64.
// - Each channel picks fast or slow clock by its own select option.
// - Channel two pulses trail channel one by exactly one oscillator period when both channels select the same clock.
// - Pin function option 0 makes the shared pin sync input, 1 mode input.
// - As mode input, pin low gives channel two PWM, high gives PFM.
// - Watchdog drops to internal oscillator when sync clock is absent or invalid.
// - Device returns to the sync clock once the watchdog sees it valid again.
// - Range option 0 accepts sync between 2000 and 3000 kHz.
// - Range option 1 accepts sync between 333 and 500 kHz.
// - General pin two config 0b10 exports channel one clock push-pull.
module scm_clock_manager
    import scm_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [3:0] osc_freq_code_default_in,
    input wire logic spread_enable_default_in,
    input wire logic [1:0] chan_two_mode_default_in,
    input wire logic fast_divider_option_in,
    input wire logic slow_divider_option_in,
    input wire logic chan_one_clock_select_in,
    input wire logic chan_two_clock_select_in,
    input wire logic pin_function_option_in,
    input wire logic sync_range_option_in,
    input wire logic [1:0] general_pin_two_config_in,
    input wire logic mode_sync_pin_in,
    output logic [3:0] osc_freq_code_out,
    output logic spread_active_out,
    output logic [4:0] spread_trim_out,
    output logic fast_switch_clock_out,
    output logic slow_switch_clock_out,
    output logic chan_one_clk_out,
    output logic chan_two_clk_out,
    output logic chan_two_pfm_out,
    output logic ext_sync_selected_out,
    output logic general_pin_two_out,
    output logic general_pin_two_oe_out
);
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [3:0] osc_freq_code_q, osc_freq_code_d;
    logic spread_enable_q, spread_enable_d;
    logic spread_rate_select_q, spread_rate_select_d;
    logic [1:0] chan_two_mode_field_q, chan_two_mode_field_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic setup_phase, hit_ctrl, hit_status, apb_write;
    logic sync_valid_q, ext_sel_q, pin_stable_q, pfm_q;

    function automatic logic freq_legal(input logic [3:0] code);
        return (code <= FREQ_HI_MAX) || (code >= FREQ_LO_MIN && code <= FREQ_LO_MAX);
    endfunction : freq_legal

    assign setup_phase = psel_in && !penable_in;
    assign hit_ctrl = (paddr_in == CTRL_OFFSET);
    assign hit_status = (paddr_in == STATUS_OFFSET);
    assign apb_write = psel_in && penable_in && pwrite_in && pready_q && !pslverr_q;

    always_comb begin
        osc_freq_code_d = osc_freq_code_q;
        spread_enable_d = spread_enable_q;
        spread_rate_select_d = spread_rate_select_q;
        chan_two_mode_field_d = chan_two_mode_field_q;
        // One wait-free access phase: ready rises in the cycle after setup
        pready_d = setup_phase;
        pslverr_d = setup_phase && !(hit_ctrl || hit_status);
        prdata_d = prdata_q;
        if (setup_phase) begin
            prdata_d = 32'h0000_0000;
            if (hit_ctrl) begin
                prdata_d[CTRL_FREQ_LSB +: 4] = osc_freq_code_q;
                prdata_d[CTRL_SPREAD_EN_BIT] = spread_enable_q;
                prdata_d[CTRL_RATE_BIT] = spread_rate_select_q;
                prdata_d[CTRL_MODE_LSB +: 2] = chan_two_mode_field_q;
            end else if (hit_status) begin
                prdata_d[STAT_VALID_BIT] = sync_valid_q;
                prdata_d[STAT_EXT_BIT] = ext_sel_q;
                prdata_d[STAT_PIN_BIT] = pin_stable_q;
                prdata_d[STAT_PFM_BIT] = pfm_q;
            end
        end
        if (apb_write && hit_ctrl) begin
            // Unused codes are dropped so the oscillator never sees them
            if (freq_legal(pwdata_in[CTRL_FREQ_LSB +: 4])) begin
                osc_freq_code_d = pwdata_in[CTRL_FREQ_LSB +: 4];
            end
            spread_enable_d = pwdata_in[CTRL_SPREAD_EN_BIT];
            spread_rate_select_d = pwdata_in[CTRL_RATE_BIT];
            chan_two_mode_field_d = pwdata_in[CTRL_MODE_LSB +: 2];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // Fused defaults are caught by the synchronous reset
            osc_freq_code_q <= freq_legal(osc_freq_code_default_in) ?
                               osc_freq_code_default_in : FREQ_RESET;
            spread_enable_q <= spread_enable_default_in;
            spread_rate_select_q <= RATE_SEL_RESET;
            chan_two_mode_field_q <= chan_two_mode_default_in;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            osc_freq_code_q <= osc_freq_code_d;
            spread_enable_q <= spread_enable_d;
            spread_rate_select_q <= spread_rate_select_d;
            chan_two_mode_field_q <= chan_two_mode_field_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // ------------------------------------------------------------
    // Spread modulation: triangle over the 5 percent span
    // ------------------------------------------------------------
    logic [5:0] spread_cnt_q, spread_cnt_d;
    logic [4:0] spread_pos_q, spread_pos_d;
    logic spread_up_q, spread_up_d;
    logic [4:0] spread_trim_q, spread_trim_d;
    logic spread_active_q;
    logic [5:0] spread_interval;

    assign spread_interval = spread_rate_select_q ? SPREAD_FAST_CYC : SPREAD_SLOW_CYC;

    always_comb begin
        spread_cnt_d = 6'(spread_cnt_q + 1'b1);
        spread_pos_d = spread_pos_q;
        spread_up_d = spread_up_q;
        if (!spread_enable_q) begin
            spread_cnt_d = 6'h00;
            spread_pos_d = 5'h00;
            spread_up_d = 1'b1;
        end else if (spread_cnt_q >= 6'(spread_interval - 1'b1)) begin
            spread_cnt_d = 6'h00;
            if (spread_up_q) begin
                spread_pos_d = 5'(spread_pos_q + 1'b1);
                spread_up_d = (spread_pos_d != SPREAD_STEPS);
            end else begin
                spread_pos_d = 5'(spread_pos_q - 1'b1);
                spread_up_d = (spread_pos_d == 5'h00);
            end
        end
        spread_trim_d = spread_enable_q ? spread_pos_q : 5'h00;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            spread_cnt_q <= 6'h00;
            spread_pos_q <= 5'h00;
            spread_up_q <= 1'b1;
            spread_trim_q <= 5'h00;
            spread_active_q <= 1'b0;
        end else begin
            spread_cnt_q <= spread_cnt_d;
            spread_pos_q <= spread_pos_d;
            spread_up_q <= spread_up_d;
            spread_trim_q <= spread_trim_d;
            spread_active_q <= spread_enable_q;
        end
    end

    // ------------------------------------------------------------
    // Shared pin: three-stage synchroniser and sync watchdog
    // ------------------------------------------------------------
    logic [2:0] pin_sync_q;
    logic pin_stable_d, pin_rise;
    logic [7:0] per_q, per_d, per_min, per_max;
    logic [1:0] good_q, good_d;
    logic sync_valid_d;

    assign per_min = sync_range_option_in ? SYNC_B_PER_MIN : SYNC_A_PER_MIN;
    assign per_max = sync_range_option_in ? SYNC_B_PER_MAX : SYNC_A_PER_MAX;
    assign pin_stable_d = (pin_sync_q[1] == pin_sync_q[2]) ? pin_sync_q[2] : pin_stable_q;
    assign pin_rise = pin_stable_d && !pin_stable_q;

    always_comb begin
        per_d = (per_q == SYNC_PER_SAT) ? SYNC_PER_SAT : 8'(per_q + 1'b1);
        good_d = good_q;
        sync_valid_d = sync_valid_q;
        if (pin_function_option_in) begin
            per_d = SYNC_PER_SAT;
            good_d = 2'h0;
            sync_valid_d = 1'b0;
        end else if (pin_rise) begin
            // Count from one so the value seen at the next edge is the period
            per_d = 8'h01;
            if (per_q >= per_min && per_q <= per_max) begin
                good_d = (good_q == SYNC_GOOD_PERIODS) ? good_q : 2'(good_q + 1'b1);
                sync_valid_d = (good_d == SYNC_GOOD_PERIODS);
            end else begin
                good_d = 2'h0;
                sync_valid_d = 1'b0;
            end
        end else if (per_q > per_max) begin
            // Missing edges count as an invalid clock
            good_d = 2'h0;
            sync_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_sync_q <= 3'h0;
            pin_stable_q <= 1'b0;
            per_q <= SYNC_PER_SAT;
            good_q <= 2'h0;
            sync_valid_q <= 1'b0;
            ext_sel_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], mode_sync_pin_in};
            pin_stable_q <= pin_stable_d;
            per_q <= per_d;
            good_q <= good_d;
            sync_valid_q <= sync_valid_d;
            ext_sel_q <= !pin_function_option_in && sync_valid_q;
        end
    end

    // ------------------------------------------------------------
    // Dividers, channel selection and interleave
    // ------------------------------------------------------------
    logic fast_p, slow_p, fast_restart, slow_restart, ch1_src, ch2_src, gp2_export;
    logic ch1_clk_q, ch2_pre_q, ch2_clk_q, fast_q, slow_q, gp2_q, gp2_oe_q;

    // Sync edges realign phase; restart pulses only past half count, so no runt below half
    // Only the divider in the sync band follows it; range option 0 edges would starve the slow one
    assign fast_restart = ext_sel_q && pin_rise && !sync_range_option_in;
    assign slow_restart = ext_sel_q && pin_rise && sync_range_option_in;
    assign ch1_src = chan_one_clock_select_in ? slow_p : fast_p;
    assign ch2_src = chan_two_clock_select_in ? slow_p : fast_p;
    assign gp2_export = (general_pin_two_config_in == GP2_CLOCK_EXPORT);

    scm_divider #(.W(DIV_W)) u_fast_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .restart_in(fast_restart),
        .ratio_in(fast_divider_option_in ? FAST_DIV_B : FAST_DIV_A),
        .pulse_out(fast_p)
    );

    scm_divider #(.W(DIV_W)) u_slow_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .restart_in(slow_restart),
        .ratio_in(slow_divider_option_in ? SLOW_DIV_B : SLOW_DIV_A),
        .pulse_out(slow_p)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ch1_clk_q <= 1'b0;
            ch2_pre_q <= 1'b0;
            ch2_clk_q <= 1'b0;
            fast_q <= 1'b0;
            slow_q <= 1'b0;
            gp2_q <= 1'b0;
            gp2_oe_q <= 1'b0;
            pfm_q <= 1'b0;
        end else begin
            ch1_clk_q <= ch1_src;
            ch2_pre_q <= ch2_src;
            ch2_clk_q <= ch2_pre_q;
            fast_q <= fast_p;
            slow_q <= slow_p;
            gp2_q <= gp2_export && ch1_src;
            gp2_oe_q <= gp2_export;
            // Register field ignored while the pin owns the mode
            pfm_q <= pin_function_option_in ? pin_stable_q
                                             : (chan_two_mode_field_q == MODE_PFM);
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign osc_freq_code_out = osc_freq_code_q;
    assign spread_active_out = spread_active_q;
    assign spread_trim_out = spread_trim_q;
    assign fast_switch_clock_out = fast_q;
    assign slow_switch_clock_out = slow_q;
    assign chan_one_clk_out = ch1_clk_q;
    assign chan_two_clk_out = ch2_clk_q;
    assign chan_two_pfm_out = pfm_q;
    assign ext_sync_selected_out = ext_sel_q;
    assign general_pin_two_out = gp2_q;
    assign general_pin_two_oe_out = gp2_oe_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_fast_gap;
        !fast_p [*7] ##1 (fast_p || fast_divider_option_in);
    endsequence

    sequence s_ctrl_write;
        apb_write && hit_ctrl && freq_legal(pwdata_in[3:0]);
    endsequence

    chk_freq_legal: assert property (freq_legal(osc_freq_code_q))
        else $error("oscillator code holds an unused value");
    chk_freq_write: assert property (s_ctrl_write |=>
        osc_freq_code_q == $past(pwdata_in[3:0]))
        else $error("legal code write not stored");
    chk_spread_off: assert property (!spread_enable_q |=> spread_trim_q == 5'h00)
        else $error("trim moves while spreading is off");
    chk_spread_span: assert property (spread_trim_q <= SPREAD_STEPS)
        else $error("trim leaves the spread span");
    chk_fast_ratio: assert property ((fast_p && !fast_divider_option_in && !ext_sel_q
        && $stable(fast_divider_option_in)) |=> s_fast_gap)
        else $error("fast clock period is not eight");
    chk_interleave: assert property ((ch1_clk_q && chan_one_clock_select_in
        == chan_two_clock_select_in && $stable(chan_two_clock_select_in)
        && $stable(chan_one_clock_select_in))
        |=> ch2_clk_q)
        else $error("channel two not one period after channel one");
    chk_mode_pin: assert property ((pin_function_option_in && $stable(pin_function_option_in))
        |=> pfm_q == $past(pin_stable_q))
        else $error("channel two mode does not follow pin");
    chk_ext_select: assert property (ext_sel_q |-> $past(sync_valid_q)
        && !$past(pin_function_option_in))
        else $error("sync clock selected while not valid");
    chk_sync_timeout: assert property ((!pin_function_option_in && per_q > per_max
        && !pin_rise) |=> !sync_valid_q ##1 !ext_sel_q)
        else $error("missing sync clock not dropped");
    chk_gp2_export: assert property (gp2_export |=> gp2_oe_q
        && gp2_q == ch1_clk_q)
        else $error("pin two not exporting channel one clock");
endmodule : scm_clock_manager

// *** verification/scm_sync_source.sv ***
// External reference clock model driving the shared mode/sync pin
`timescale 1ns/1ps
module scm_sync_source (
    input wire logic run_in,
    input wire logic level_in,
    input wire logic [15:0] half_ns_in,
    output logic pin_out
);
    // ------------------------------------------------------------
    // Clock source
    // ------------------------------------------------------------
    // Odd start offset keeps the phase unrelated to the system clock
    initial begin
        pin_out = 1'b0;
        #7;
        forever begin
            if (run_in) begin
                pin_out = 1'b1;
                #(half_ns_in);
                pin_out = 1'b0;
                #(half_ns_in);
            end else begin
                // Stopped source parks at the mode level
                pin_out = level_in;
                @(run_in or level_in);
            end
        end
    end
endmodule : scm_sync_source

// *** verification/switching_clock_manager_bench.sv ***
// Self-checking bench for the switching clock manager
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin failures++; \
    $display("BAD %s exp %0h seen %0h", nm, e, s); end end
module switching_clock_manager_bench import scm_pkg::*; ;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} scm_note_t;
    logic clk_in, rst_in, psel, pen, pwr, pready, pslverr, sdef, fo, so, s1, s2, pf, ro;
    logic run, lvl, pin, act, fc, sc, c1, c2, pfm, ext, g2, g2oe, c1p, chk;
    logic [7:0] pa;
    logic [31:0] pwd, prd, d;
    logic [3:0] cdef, code, prev;
    logic [1:0] mdef, gcfg;
    logic [15:0] half;
    logic [4:0] trim;
    logic [3:0] lanes;
    int failures, compares, seed, cnt[4], gap[4], ef, es;
    scm_note_t q[$], nt;
    scm_clock_manager DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(pready), .pslverr_out(pslverr),
        .osc_freq_code_default_in(cdef), .spread_enable_default_in(sdef),
        .chan_two_mode_default_in(mdef), .fast_divider_option_in(fo),
        .slow_divider_option_in(so), .chan_one_clock_select_in(s1),
        .chan_two_clock_select_in(s2), .pin_function_option_in(pf),
        .sync_range_option_in(ro), .general_pin_two_config_in(gcfg),
        .mode_sync_pin_in(pin), .osc_freq_code_out(code), .spread_active_out(act),
        .spread_trim_out(trim), .fast_switch_clock_out(fc), .slow_switch_clock_out(sc),
        .chan_one_clk_out(c1), .chan_two_clk_out(c2), .chan_two_pfm_out(pfm),
        .ext_sync_selected_out(ext), .general_pin_two_out(g2),
        .general_pin_two_oe_out(g2oe));
    scm_sync_source src (.run_in(run), .level_in(lvl), .half_ns_in(half), .pin_out(pin));
    // ------------------------------------------------------------
    // Watcher: pulse gaps, lanes, read results
    // ------------------------------------------------------------
    always @(negedge clk_in) begin
        lanes = {c2, c1, sc, fc};
        for (int k = 0; k < 4; k++) begin
            cnt[k]++;
            if (lanes[k] === 1'b1) begin
                gap[k] = cnt[k];
                cnt[k] = 0;
            end
        end
        if (chk === 1'b1) begin
            `CHK("ch2_lag", c1p, c2)
            `CHK("gp2_out", c1, g2)
        end
        c1p = c1;
    end
    // Read data taken at the edge that samples pready
    always @(posedge clk_in) begin
        if (psel && pen && pready === 1'b1 && !pwr) begin
            nt = q.pop_front();
            `CHK("prdata", nt.d, prd & nt.m)
            `CHK("pslverr", nt.e, pslverr)
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= v;
        @(posedge clk_in);
        pen <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) failures++;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] v, m, input logic e);
        q.push_back({v, m, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wext(input logic e, input int lim, input int hold);
        int n;
        n = 0;
        @(negedge clk_in);
        while (ext !== e && n < lim) begin
            @(negedge clk_in);
            n++;
        end
        repeat (hold) begin
            @(negedge clk_in);
            if (ext !== e) n = lim;
        end
        `CHK("ext_sel", 1'b1, n < lim)
        @(posedge clk_in);
    endtask : wext
    task automatic report_and_stop;
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    initial begin
        #1000000;
        failures++;
        report_and_stop();
    end
    initial begin
        {psel, pen, pwr, pa, pwd, fo, so, s1, s2, ro, run, lvl, chk} = '0;
        {rst_in, pf, sdef, cdef, mdef, gcfg, half, seed} = {3'h7, 4'h9, 4'hE, 16'hCB, 77};
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(negedge clk_in);
        `CHK("code_rst", 4'h9, code)
        rd(CTRL_OFFSET, 32'hD9, 32'hFF, 1'b0);
        rd(8'h08, 32'h0, 32'hFFFFFFFF, 1'b1);
        prev = 4'h9;
        for (int c = 0; c < 16; c++) begin
            d = $random(seed);
            d[7:0] = {4'hC, 4'(c)};
            apb(1'b1, CTRL_OFFSET, d);
            if (c <= 4 || (c >= 9 && c <= 12)) prev = 4'(c);
            @(negedge clk_in);
            `CHK("code", prev, code)
        end
        apb(1'b1, CTRL_OFFSET, 32'hFC);
        repeat (40) @(negedge clk_in);
        `CHK("spread", 1'b1, act && trim != 0 && trim <= 16)
        apb(1'b1, CTRL_OFFSET, 32'hCC);
        repeat (3) @(negedge clk_in);
        `CHK("spread_off", 6'h0, {act, trim})
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_in);
            lvl <= 1'(i ^ 1);
            repeat (10) @(negedge clk_in);
            `CHK("pfm_pin", 1'(i ^ 1), pfm)
        end
        @(posedge clk_in);
        pf <= 1'b0;
        apb(1'b1, CTRL_OFFSET, 32'h0C);
        repeat (2) @(negedge clk_in);
        `CHK("pfm_reg", 1'b1, pfm)
        apb(1'b1, CTRL_OFFSET, 32'hCC);
        pf <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            {fo, so, s1, s2} <= (i < 4) ? {2'(i), {2{1'(i >> 1)}}} : 4'h1;
            chk <= 1'b0;
            repeat (200) @(posedge clk_in);
            chk <= (i < 4);
            repeat (140) @(posedge clk_in);
            ef = fo ? FAST_DIV_B : FAST_DIV_A;
            es = so ? SLOW_DIV_B : SLOW_DIV_A;
            `CHK("fast_gap", ef, gap[0])
            `CHK("slow_gap", es, gap[1])
            `CHK("ch1_gap", s1 ? es : ef, gap[2])
            `CHK("ch2_gap", s2 ? es : ef, gap[3])
        end
        chk <= 1'b0;
        gcfg <= 2'h0;
        repeat (3) @(negedge clk_in);
        `CHK("gp2_oe", 1'b0, g2oe)
        @(posedge clk_in);
        {pf, run} <= 2'h1;
        wext(1'b1, 80, 20);
        rd(STATUS_OFFSET, 32'h3, 32'h3, 1'b0);
        run <= 1'b0;
        wext(1'b0, 40, 20);
        run <= 1'b1;
        wext(1'b1, 80, 20);
        half <= 16'd1201;
        wext(1'b0, 100, 300);
        ro <= 1'b1;
        wext(1'b1, 400, 100);
        half <= 16'd203;
        wext(1'b0, 100, 200);
        half <= 16'd1201;
        wext(1'b1, 400, 20);
        pf <= 1'b1;
        wext(1'b0, 20, 100);
        report_and_stop();
    end
endmodule : switching_clock_manager_bench
